// ===== sim/frp_fault_reaction_chk.sv
// Checker for the fault reaction policy block
`timescale 1ns/1ps
`default_nettype none
module frp_fault_reaction_chk #(
	parameter int unsigned NPH = 3
) (
	// Clock and reset
	input wire logic           mclk,
	input wire logic           rst,
	// Detections and clears
	input wire logic           vb_uv_a,
	input wire logic           vb_uv_b,
	input wire logic           vcc_uv,
	input wire logic           spi_error,
	input wire logic           clr_spi,
	// Flags
	input wire logic           flag_ovc,
	input wire logic           flag_tsd,
	input wire logic [NPH-1:0] flag_sc,
	input wire logic           flag_frq,
	input wire logic           flag_inh,
	input wire logic           flag_spi,
	// Controlled circuits
	input wire logic [NPH-1:0] phase_en,
	input wire logic           relay_en,
	input wire logic           cpump_en,
	input wire logic           divider_en,
	input wire logic           short_det_en,
	input wire logic           fault_indicator_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_uvb;
		vb_uv_a || vb_uv_b |=> phase_en == '0 && !relay_en;
	endproperty
	a_uvb: assert property (p_uvb) else $error("drivers on in battery undervoltage");
	property p_vuv;
		vcc_uv |=> phase_en == '0 && !cpump_en && !divider_en && !fault_indicator_n;
	endproperty
	a_vuv: assert property (p_vuv) else $error("logic undervoltage not acted on");
	property p_spi;
		spi_error |=> flag_spi && !fault_indicator_n && cpump_en;
	endproperty
	a_spi: assert property (p_spi) else $error("serial error not reported");
	property p_hold;
		flag_spi && !clr_spi |=> flag_spi;
	endproperty
	a_hold: assert property (p_hold) else $error("latched flag lost");
	property p_diag;
		flag_ovc || flag_tsd || flag_frq || flag_inh || flag_spi || |flag_sc |-> !fault_indicator_n;
	endproperty
	a_diag: assert property (p_diag) else $error("indicator high with flag set");
	property p_relay;
		!relay_en |-> phase_en == '0;
	endproperty
	a_relay: assert property (p_relay) else $error("phase on with relays off");
	property p_pump;
		!cpump_en |-> !relay_en && phase_en == '0;
	endproperty
	a_pump: assert property (p_pump) else $error("pump off with drivers on");
	property p_sdet;
		vcc_uv [*2] |=> !short_det_en;
	endproperty
	a_sdet: assert property (p_sdet) else $error("short detect on while drivers off");
endmodule
bind frp_fault_reaction frp_fault_reaction_chk #(.NPH(NPH)) i_frp_fault_reaction_chk (
	.mclk, .rst, .vb_uv_a, .vb_uv_b, .vcc_uv, .spi_error, .clr_spi, .flag_ovc, .flag_tsd,
	.flag_sc, .flag_frq, .flag_inh, .flag_spi, .phase_en, .relay_en, .cpump_en,
	.divider_en, .short_det_en, .fault_indicator_n
);
`default_nettype wire

// ===== sim/frp_fault_reaction_tb.sv
// Testbench for the fault reaction policy block
`timescale 1ns/1ps
`default_nettype none
module frp_fault_reaction_tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic vb_uv_a, vb_uv_b, vcc_uv, vcc_ov, over_temp, clk_abnormal, spi_error;
	logic [2:0] fet_short, hs_cmd, ls_cmd, flag_sc, phase_en;
	logic flag_uvb, flag_ovc, flag_tsd, flag_frq, flag_inh, flag_spi;
	logic relay_en, cpump_en, divider_en, short_det_en, fault_indicator_n;
	wire logic [1:0] vb_mode, ov_mode, ot_mode;
	wire logic [2:0] sc_mode, frq_mode;
	wire logic inh_mode;
	wire logic [8:0] clr;
	wire logic [6:0] obs = {phase_en, relay_en, cpump_en, divider_en, fault_indicator_n};
	wire logic [8:0] flg = {flag_spi, flag_inh, flag_frq, flag_sc, flag_tsd, flag_ovc, flag_uvb};
	logic [6:0] tr [4] = '{7'h7e, 7'h06, 7'h02, 7'h02};
	logic [6:0] sc [8] = '{7'h7e, 7'h5e, 7'h5e, 7'h06, 7'h06, 7'h02, 7'h02, 7'h7f};
	logic [6:0] scr [8] = '{7'h7e, 7'h7e, 7'h5e, 7'h7e, 7'h06, 7'h7e, 7'h02, 7'h7f};
	int err_count = 0;
	int compares = 0;
	always #5 mclk = ~mclk;
	frp_host_model i_frp_host_model (
		.mclk, .vb_mode, .ov_mode, .ot_mode, .sc_mode, .frq_mode, .inh_mode, .clr
	);
	frp_fault_reaction i_frp_fault_reaction (
		.mclk, .rst, .vb_uv_a, .vb_uv_b, .vcc_uv, .vcc_ov, .over_temp, .fet_short,
		.clk_abnormal, .spi_error, .hs_cmd, .ls_cmd, .vb_mode, .ov_mode, .ot_mode,
		.sc_mode, .frq_mode, .inh_mode, .clr_uvb(clr[0]), .clr_ovc(clr[1]),
		.clr_tsd(clr[2]), .clr_sc(clr[5:3]), .clr_frq(clr[6]), .clr_inh(clr[7]),
		.clr_spi(clr[8]), .flag_uvb, .flag_ovc, .flag_tsd, .flag_sc, .flag_frq,
		.flag_inh, .flag_spi, .phase_en, .relay_en, .cpump_en, .divider_en,
		.short_det_en, .fault_indicator_n
	);
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk(input string nm, input logic [8:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
			err_count++;
		end
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Mode set, fault raised, released, host clear
	task automatic fault(input int s, input logic [2:0] m, input logic [6:0] on, rel);
		logic [8:0] fe;
		fe = ((s == 7 && m == 3'h0) || (s == 6 && m[2]) || (s == 4 && m == 3'h7)) ? 9'h0 : 9'h1 << s;
		@(posedge mclk);
		case (s)
			0: i_frp_host_model.vb_mode <= m[1:0];
			1: i_frp_host_model.ov_mode <= m[1:0];
			2: i_frp_host_model.ot_mode <= m[1:0];
			4: i_frp_host_model.sc_mode <= m;
			6: i_frp_host_model.frq_mode <= m;
			7: i_frp_host_model.inh_mode <= m[0];
			default: ;
		endcase
		wt(3);
		case (s)
			0: {vb_uv_b, vb_uv_a} <= m[0] ? 2'h2 : 2'h1;
			1: vcc_ov <= 1'b1;
			2: over_temp <= 1'b1;
			4: fet_short <= 3'h2;
			6: clk_abnormal <= 1'b1;
			7: {hs_cmd, ls_cmd} <= 6'h09;
			8: spi_error <= 1'b1;
			default: vcc_uv <= 1'b1;
		endcase
		wt(s == 7 ? 7 : 2);
		chk("outputs in fault", {2'h0, obs}, {2'h0, on});
		chk("flags in fault", flg, fe);
		wt(1);
		chk("outputs held in fault", {2'h0, obs}, {2'h0, on});
		{vb_uv_a, vb_uv_b, vcc_uv, vcc_ov, over_temp, clk_abnormal, spi_error} <= '0;
		{fet_short, hs_cmd, ls_cmd} <= '0;
		wt(s == 7 ? 7 : 3);
		chk("outputs after release", {2'h0, obs}, {2'h0, rel});
		i_frp_host_model.clear(fe);
		wt(3);
		chk("outputs after clear", {2'h0, obs}, 9'h07f);
		chk("flags after clear", flg, 9'h0);
		$display("test source %0d mode %0d done", s, m);
	endtask
	initial
	begin
		#100000;
		err_count++;
		end_sim();
	end
	initial
	begin
		{vb_uv_a, vb_uv_b, vcc_uv, vcc_ov, over_temp, clk_abnormal, spi_error} = '0;
		{fet_short, hs_cmd, ls_cmd} = '0;
		wt(8);
		rst <= 1'b0;
		wt(3);
		chk("reset outputs", {2'h0, obs}, 9'h07f);
		chk("reset flags", flg, 9'h0);
		fault(0, 3'h0, 7'h06, 7'h7e);
		fault(0, 3'h1, 7'h06, 7'h7f);
		fault(0, 3'h2, 7'h07, 7'h7f);
		fault(9, 3'h0, 7'h00, 7'h7f);
		for (int m = 0; m < 4; m++)
		begin
			fault(1, m[2:0], tr[m], m == 3 ? 7'h02 : 7'h7e);
			fault(2, m[2:0], tr[m], m == 3 ? 7'h02 : 7'h7e);
			fault(6, m[2:0], tr[m], m == 3 ? 7'h02 : 7'h7e);
		end
		fault(6, 3'h4, 7'h7f, 7'h7f);
		for (int m = 0; m < 8; m++)
			fault(4, m[2:0], sc[m], scr[m]);
		fault(7, 3'h0, 7'h6f, 7'h7f);
		fault(7, 3'h1, 7'h6e, 7'h7e);
		fault(8, 3'h0, 7'h7e, 7'h7e);
		i_frp_host_model.ov_mode <= frp_pkg::TRIP_MODE_LATCH;
		wt(3);
		vcc_ov <= 1'b1;
		wt(2);
		i_frp_host_model.ov_mode <= frp_pkg::TRIP_MODE_RUN;
		wt(2);
		vcc_ov <= 1'b0;
		wt(3);
		chk("mode frozen in fault", {2'h0, obs}, 9'h002);
		i_frp_host_model.clear(9'h002);
		wt(3);
		chk("mode taken after clear", {2'h0, obs}, 9'h07f);
		vcc_ov <= 1'b1;
		wt(2);
		chk("new mode applied", {2'h0, obs}, 9'h07e);
		vcc_ov <= 1'b0;
		i_frp_host_model.clear(9'h002);
		$display("test mode freeze done");
		end_sim();
	end
endmodule
`default_nettype wire

// ===== sim/frp_host_model.sv
// Host model: mode fields and flag clear strobes
`timescale 1ns/1ps
`default_nettype none
module frp_host_model (
	// Clock
	input wire logic   mclk,
	// Mode fields
	output logic [1:0] vb_mode,
	output logic [1:0] ov_mode,
	output logic [1:0] ot_mode,
	output logic [2:0] sc_mode,
	output logic [2:0] frq_mode,
	output logic       inh_mode,
	// Clear strobes
	output logic [8:0] clr
);
	initial
	begin
		vb_mode = frp_pkg::VB_MODE_RST;
		ov_mode = frp_pkg::OV_MODE_RST;
		ot_mode = frp_pkg::OT_MODE_RST;
		sc_mode = frp_pkg::SC_MODE_RST;
		frq_mode = frp_pkg::FRQ_MODE_RST;
		inh_mode = frp_pkg::INH_MODE_RST;
		clr = 9'h0;
	end
	// One-cycle clear once the condition is gone
	task automatic clear(input logic [8:0] m);
		@(posedge mclk);
		clr <= m;
		@(posedge mclk);
		clr <= 9'h0;
	endtask
endmodule
`default_nettype wire

// ===== src/frp_fault_reaction.sv
// Fault reaction policy: detection inputs to shutdown, flags and indicator
`timescale 1ns/1ps
`default_nettype none
//
// Summary of operation
// R1: Either battery supply path flags undervoltage
// R2: Battery undervoltage always stops drivers; mode sets indicator
// R3: Logic undervoltage stops drivers, pump, divider; indicator low
// R4: Logic overvoltage reacts per two-bit mode
// R5: Over-temperature reacts per two-bit mode
// R6: FET short reacts per three-bit mode
// R7: Short mode 111 masks FET shorts from flag, shutdown and indicator
// R8: Clock abnormality reacts per mode; 1xx disables
// R9: Inhibit stops phase drivers; setting picks reporting
// R10: SPI error flags and holds indicator low only
// R11: Plain shutdown self-recovers; latched shutdown holds
// R12: Latched indicator stays low after condition clears
// R13: Unlatched flag and indicator follow the condition
// R14: Full shutdown includes relays; phase shutdown local
// R15: Short detection off while drivers are fully shut down by any fault other than a short
// R16: Mode change waits for release and cleared flag
// R17: Host clear after release restores operation
// R18: Runs on the internal logic clock
// R19: Concurrent faults combine their shutdowns
module frp_fault_reaction #(
	parameter int unsigned NPH = frp_pkg::NUM_PHASES
) (
	// Clock and reset
	input  wire logic           mclk,
	input  wire logic           rst,
	// Filtered detections
	input  wire logic           vb_uv_a,
	input  wire logic           vb_uv_b,
	input  wire logic           vcc_uv,
	input  wire logic           vcc_ov,
	input  wire logic           over_temp,
	input  wire logic [NPH-1:0] fet_short,
	input  wire logic           clk_abnormal,
	input  wire logic           spi_error,
	// Phase command pins
	input  wire logic [NPH-1:0] hs_cmd,
	input  wire logic [NPH-1:0] ls_cmd,
	// Mode fields
	input  wire logic [1:0]     vb_mode,
	input  wire logic [1:0]     ov_mode,
	input  wire logic [1:0]     ot_mode,
	input  wire logic [2:0]     sc_mode,
	input  wire logic [2:0]     frq_mode,
	input  wire logic           inh_mode,
	// Flag clear strobes
	input  wire logic           clr_uvb,
	input  wire logic           clr_ovc,
	input  wire logic           clr_tsd,
	input  wire logic [NPH-1:0] clr_sc,
	input  wire logic           clr_frq,
	input  wire logic           clr_inh,
	input  wire logic           clr_spi,
	// Fault flags
	output logic                flag_uvb,
	output logic                flag_ovc,
	output logic                flag_tsd,
	output logic [NPH-1:0]      flag_sc,
	output logic                flag_frq,
	output logic                flag_inh,
	output logic                flag_spi,
	// Controlled circuits
	output logic [NPH-1:0]      phase_en,
	output logic                relay_en,
	output logic                cpump_en,
	output logic                divider_en,
	output logic                short_det_en,
	output logic                fault_indicator_n
);

	typedef struct packed {
		logic [NPH-1:0] hs_s1;
		logic [NPH-1:0] hs_s2;
		logic [NPH-1:0] hs_s3;
		logic [NPH-1:0] ls_s1;
		logic [NPH-1:0] ls_s2;
		logic [NPH-1:0] ls_s3;
		logic [NPH-1:0] hs_f;
		logic [NPH-1:0] ls_f;
		logic [1:0]     vb_m;
		logic [1:0]     ov_m;
		logic [1:0]     ot_m;
		logic [2:0]     sc_m;
		logic [2:0]     frq_m;
		logic           inh_m;
		logic           uvb;
		logic           ovc;
		logic           tsd;
		logic [NPH-1:0] sc;
		logic           frq;
		logic           inh;
		logic           spi;
		logic           sc_en;
		logic [NPH-1:0] ph_en;
		logic           rly_en;
		logic           cp_en;
		logic           div_en;
		logic           ind_n;
	} frp_state_t;

	frp_state_t s_q;
	frp_state_t s_d;

	// Per-bit command pin filter
	logic [NPH-1:0] hs_filt;
	logic [NPH-1:0] ls_filt;

	genvar gi;
	generate
		for (gi = 0; gi < NPH; gi++)
		begin : g_pin
			assign hs_filt[gi] = (s_q.hs_s2[gi] == s_q.hs_s3[gi]) ? s_q.hs_s3[gi] : s_q.hs_f[gi];
			assign ls_filt[gi] = (s_q.ls_s2[gi] == s_q.ls_s3[gi]) ? s_q.ls_s3[gi] : s_q.ls_f[gi];
		end
	endgenerate

	always_comb
	begin
		logic           vb_det;
		logic           ov_det;
		logic           ot_det;
		logic [NPH-1:0] sc_det;
		logic           frq_det;
		logic [NPH-1:0] inh_det;
		logic           ov_lat;
		logic           ot_lat;
		logic           sc_lat;
		logic           frq_lat;
		logic           ov_act;
		logic           ot_act;
		logic [NPH-1:0] sc_act;
		logic           frq_act;
		logic           off_all;
		logic           off_cp;
		logic           off_div;
		logic [NPH-1:0] off_ph;
		logic           ind_low;
		vb_det  = 1'b0;
		ov_det  = 1'b0;
		ot_det  = 1'b0;
		sc_det  = '0;
		frq_det = 1'b0;
		inh_det = '0;
		ov_lat  = 1'b0;
		ot_lat  = 1'b0;
		sc_lat  = 1'b0;
		frq_lat = 1'b0;
		ov_act  = 1'b0;
		ot_act  = 1'b0;
		sc_act  = '0;
		frq_act = 1'b0;
		off_all = 1'b0;
		off_cp  = 1'b0;
		off_div = 1'b0;
		off_ph  = '0;
		ind_low = 1'b0;
		s_d = s_q;

		// Command pin synchronisers
		s_d.hs_s1 = hs_cmd;
		s_d.hs_s2 = s_q.hs_s1;
		s_d.hs_s3 = s_q.hs_s2;
		s_d.ls_s1 = ls_cmd;
		s_d.ls_s2 = s_q.ls_s1;
		s_d.ls_s3 = s_q.ls_s2;
		s_d.hs_f  = hs_filt;
		s_d.ls_f  = ls_filt;

		// Qualified detections
		vb_det  = vb_uv_a | vb_uv_b; // see R1
		ov_det  = vcc_ov;
		ot_det  = over_temp;
		sc_det  = (s_q.sc_m == frp_pkg::SC_MODE_OFF) ? '0 : fet_short; // see R7
		sc_det  = s_q.sc_en ? sc_det : '0; // see R15
		frq_det = clk_abnormal & ~s_q.frq_m[frp_pkg::FRQ_OFF_BIT]; // see R8
		inh_det = s_q.hs_f & s_q.ls_f;

		// Latched reactions held while the flag stands
		ov_lat  = (s_q.ov_m == frp_pkg::TRIP_MODE_LATCH);
		ot_lat  = (s_q.ot_m == frp_pkg::TRIP_MODE_LATCH);
		sc_lat  = (s_q.sc_m == frp_pkg::SC_MODE_PH_LAT) | (s_q.sc_m == frp_pkg::SC_MODE_ALL_LAT)
			| (s_q.sc_m == frp_pkg::SC_MODE_CP_LAT);
		frq_lat = (s_q.frq_m == frp_pkg::FRQ_MODE_LATCH);
		ov_act  = ov_det | (s_q.ovc & ov_lat); // see R11
		ot_act  = ot_det | (s_q.tsd & ot_lat); // see R11
		sc_act  = sc_det | (s_q.sc & {NPH{sc_lat}}); // see R11
		frq_act = frq_det | (s_q.frq & frq_lat); // see R11

		// Shutdown union
		if (vb_det)
		begin
			off_all = 1'b1; // see R2
		end
		if (vcc_uv)
		begin
			off_all = 1'b1; // see R3
			off_cp  = 1'b1;
			off_div = 1'b1;
		end
		if (ov_act && s_q.ov_m != frp_pkg::TRIP_MODE_RUN)
		begin
			off_all = 1'b1; // see R4
			off_cp  = off_cp | (s_q.ov_m != frp_pkg::TRIP_MODE_PD);
		end
		if (ot_act && s_q.ot_m != frp_pkg::TRIP_MODE_RUN)
		begin
			off_all = 1'b1; // see R5
			off_cp  = off_cp | (s_q.ot_m != frp_pkg::TRIP_MODE_PD);
		end
		if (frq_act && s_q.frq_m != frp_pkg::FRQ_MODE_RUN)
		begin
			off_all = 1'b1; // see R8
			off_cp  = off_cp | (s_q.frq_m != frp_pkg::FRQ_MODE_PD);
		end
		s_d.sc_en = ~off_all; // see R15
		case (s_q.sc_m)
			frp_pkg::SC_MODE_PH, frp_pkg::SC_MODE_PH_LAT:
			begin
				off_ph = off_ph | sc_act; // see R6
			end
			frp_pkg::SC_MODE_ALL, frp_pkg::SC_MODE_ALL_LAT:
			begin
				off_all = off_all | (|sc_act); // see R6
			end
			frp_pkg::SC_MODE_CP, frp_pkg::SC_MODE_CP_LAT:
			begin
				off_all = off_all | (|sc_act); // see R6
				off_cp  = off_cp | (|sc_act);
			end
			default: off_ph = off_ph;
		endcase
		off_ph = off_ph | inh_det; // see R9

		// Fault register writes, set wins over clear
		if (s_q.vb_m == frp_pkg::VB_MODE_HOLD)
		begin
			s_d.uvb = vb_det | (s_q.uvb & ~clr_uvb); // see R12
		end
		else
		begin
			s_d.uvb = vb_det; // see R13
		end
		s_d.ovc = ov_det | (s_q.ovc & ~clr_ovc); // see R4
		s_d.tsd = ot_det | (s_q.tsd & ~clr_tsd); // see R5
		s_d.sc  = sc_det | (s_q.sc & ~clr_sc); // see R7
		s_d.frq = frq_det | (s_q.frq & ~clr_frq); // see R8
		s_d.inh = (s_q.inh_m & |inh_det) | (s_q.inh & ~clr_inh); // see R9
		s_d.spi = spi_error | (s_q.spi & ~clr_spi); // see R10

		// Mode fields accepted only when idle
		if (!vb_det && !s_q.uvb)
		begin
			s_d.vb_m = vb_mode; // see R16
		end
		if (!ov_det && !s_q.ovc)
		begin
			s_d.ov_m = ov_mode; // see R16
		end
		if (!ot_det && !s_q.tsd)
		begin
			s_d.ot_m = ot_mode; // see R16
		end
		if (!(|fet_short) && !(|s_q.sc))
		begin
			s_d.sc_m = sc_mode; // see R16
		end
		if (!clk_abnormal && !s_q.frq)
		begin
			s_d.frq_m = frq_mode; // see R16
		end
		if (!(|inh_det) && !s_q.inh)
		begin
			s_d.inh_m = inh_mode; // see R16
		end

		// Indicator union
		ind_low = vcc_uv | s_d.ovc | s_d.tsd | (|s_d.sc) | s_d.frq | s_d.inh | s_d.spi; // see R19
		if (s_q.vb_m == frp_pkg::VB_MODE_HOLD)
		begin
			ind_low = ind_low | s_d.uvb; // see R2
		end
		else if (s_q.vb_m == frp_pkg::VB_MODE_LOW)
		begin
			ind_low = ind_low | vb_det; // see R2
		end

		// Registered outputs
		s_d.ph_en  = ~({NPH{off_all}} | off_ph); // see R14
		s_d.rly_en = ~off_all; // see R14
		s_d.cp_en  = ~off_cp; // see R19
		s_d.div_en = ~off_div;
		s_d.ind_n  = ~ind_low; // see R17
	end

	// State register on the logic clock
	always_ff @(posedge mclk) // see R18
	begin
		if (rst)
		begin
			s_q        <= '0;
			s_q.vb_m   <= frp_pkg::VB_MODE_RST;
			s_q.ov_m   <= frp_pkg::OV_MODE_RST;
			s_q.ot_m   <= frp_pkg::OT_MODE_RST;
			s_q.sc_m   <= frp_pkg::SC_MODE_RST;
			s_q.frq_m  <= frp_pkg::FRQ_MODE_RST;
			s_q.inh_m  <= frp_pkg::INH_MODE_RST;
			s_q.sc_en  <= 1'b1;
			s_q.ph_en  <= '1;
			s_q.rly_en <= 1'b1;
			s_q.cp_en  <= 1'b1;
			s_q.div_en <= 1'b1;
			s_q.ind_n  <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign flag_uvb          = s_q.uvb;
	assign flag_ovc          = s_q.ovc;
	assign flag_tsd          = s_q.tsd;
	assign flag_sc           = s_q.sc;
	assign flag_frq          = s_q.frq;
	assign flag_inh          = s_q.inh;
	assign flag_spi          = s_q.spi;
	assign phase_en          = s_q.ph_en;
	assign relay_en          = s_q.rly_en;
	assign cpump_en          = s_q.cp_en;
	assign divider_en        = s_q.div_en;
	assign short_det_en      = s_q.sc_en;
	assign fault_indicator_n = s_q.ind_n;

endmodule
`default_nettype wire

// ===== src/frp_pkg.sv
// Constants for the fault reaction policy block
package frp_pkg;

	// Phase count
	localparam int unsigned NUM_PHASES = 3;

	// Supply-B undervoltage modes
	localparam logic [1:0] VB_MODE_HOLD = 2'h0;
	localparam logic [1:0] VB_MODE_LOW  = 2'h1;
	localparam logic [1:0] VB_MODE_RST  = 2'h1;

	// Logic-supply overvoltage and over-temperature modes
	localparam logic [1:0] TRIP_MODE_RUN    = 2'h0;
	localparam logic [1:0] TRIP_MODE_PD     = 2'h1;
	localparam logic [1:0] TRIP_MODE_PD_CP  = 2'h2;
	localparam logic [1:0] TRIP_MODE_LATCH  = 2'h3;
	localparam logic [1:0] OV_MODE_RST      = 2'h1;
	localparam logic [1:0] OT_MODE_RST      = 2'h2;

	// FET short modes
	localparam logic [2:0] SC_MODE_RUN      = 3'h0;
	localparam logic [2:0] SC_MODE_PH       = 3'h1;
	localparam logic [2:0] SC_MODE_PH_LAT   = 3'h2;
	localparam logic [2:0] SC_MODE_ALL      = 3'h3;
	localparam logic [2:0] SC_MODE_ALL_LAT  = 3'h4;
	localparam logic [2:0] SC_MODE_CP       = 3'h5;
	localparam logic [2:0] SC_MODE_CP_LAT   = 3'h6;
	localparam logic [2:0] SC_MODE_OFF      = 3'h7;
	localparam logic [2:0] SC_MODE_RST      = 3'h2;

	// Clock-frequency monitor modes
	localparam logic [2:0] FRQ_MODE_RUN     = 3'h0;
	localparam logic [2:0] FRQ_MODE_PD      = 3'h1;
	localparam logic [2:0] FRQ_MODE_PD_CP   = 3'h2;
	localparam logic [2:0] FRQ_MODE_LATCH   = 3'h3;
	localparam int unsigned FRQ_OFF_BIT     = 2;
	localparam logic [2:0] FRQ_MODE_RST     = 3'h4;

	// Inhibit reporting setting
	localparam logic       INH_MODE_RST     = 1'b0;

endpackage
